// File: src/ihsr_map.vh
// Register map, field positions, reset values and mode codes of the I2C host
// start/restart controller. Assumes an 8-bit register port and a 100 MHz MCLK_I.
// How it works
// - Host logic runs only with host mode code selected and the port enabled.
// - Hardware pulls SDA or SCL low through output enables when needed.
// - Start-seen and stop-seen clear on reset and while the port is disabled.
// - Firmware mode: only start/stop detection runs; software drives both lines.
// - Interrupt flag sets on start, stop, byte, acknowledge and repeated start.
// - No queuing: buffer write before a start completes is dropped, flags collision.
// - Own start/stop detection suspended while generating; flag set at completion.
// - Repeated start ends a transfer and keeps the bus owned, SCL low.
// - First byte after start is seven-bit address plus direction bit.
// - Eight bits per byte, host drives SCL, receiver acknowledges every byte.
// - Released SCL stalls baud generator until sampled high, then reloads.
// - Buffer write during any sequence is dropped and sets write collision.
// - Low five bits of second control register ignored until start completes.
// - Start: both lines high, load generator; at timeout pull SDA low, flag start.
// - Reload after SDA low; at timeout clear start request, keep SDA low.
// - Lines low at start or SCL low before SDA driven: collision, abort, idle.
// - Repeated-start request accepted only while the host machine is inactive.
// - Restart: SCL low, release SDA, count; SDA high releases SCL; high period.
// - Then SDA low one period, SCL low, clear request without reloading; the code reloads the generator on its return to idle.
// - Restart: start-seen set on detection; interrupt only after timeout.
// - Restart collision: SDA low when SCL rises, or SCL falls before SDA low.
`ifndef IHSR_MAP_VH
`define IHSR_MAP_VH

// --------------------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------------------
`define IHSR_OFF_CTL1 8'h00
`define IHSR_OFF_CTL2 8'h04
`define IHSR_OFF_STAT 8'h08
`define IHSR_OFF_BAUD 8'h0c
`define IHSR_OFF_BUF 8'h10

// --------------------------------------------------------------------------
// First control register fields
// --------------------------------------------------------------------------
`define IHSR_C1_MODE_HI 3
`define IHSR_C1_MODE_LO 0
`define IHSR_C1_FW_SCL 4
`define IHSR_C1_EN 5
`define IHSR_C1_FW_SDA 6
`define IHSR_C1_WRITE_COLLISION_FLAG 7

// --------------------------------------------------------------------------
// Second control register fields
// --------------------------------------------------------------------------
`define IHSR_C2_START 0
`define IHSR_C2_RSTART 1
`define IHSR_C2_STOP 2
`define IHSR_C2_RX 3
`define IHSR_C2_ACKEN 4
`define IHSR_C2_ACKDATA 5
`define IHSR_C2_ACKSTAT 6

// --------------------------------------------------------------------------
// Status register fields
// --------------------------------------------------------------------------
`define IHSR_ST_START 0
`define IHSR_ST_STOP 1
`define IHSR_ST_IRQ 2
`define IHSR_ST_BCOL 3
`define IHSR_ST_FULL 4
`define IHSR_ST_BUSY 5

// --------------------------------------------------------------------------
// Mode codes, reset values, byte framing
// --------------------------------------------------------------------------
`define IHSR_MODE_HOST 4'h8
`define IHSR_MODE_FW 4'hb
`define IHSR_RST_BAUD 8'h04
`define IHSR_BITS_TX 4'h9
`define IHSR_BITS_RX 4'h8
`define IHSR_BITS_ACK 4'h1

`endif

// File: src/ihsr_core.v
// I2C host controller: start, repeated start, stop, byte shift and acknowledge
// generation with collision checks and start/stop detection.
// Assumes open-drain SDA/SCL resolved outside; pins are asynchronous to MCLK_I.
`timescale 1ns/1ns
`include "ihsr_map.vh"

module ihsr_core (
	input wire MCLK_I,
	input wire RST_I,
	input wire [7:0] ADDR_I,
	input wire [7:0] WDATA_I,
	input wire WR_I,
	input wire RD_I,
	output reg [7:0] RDATA_O,
	input wire SDA_I,
	input wire SCL_I,
	output reg SDA_O,
	output reg SDA_OE_O,
	output reg SCL_O,
	output reg SCL_OE_O
);

	// --------------------------------------------------------------------
	// States
	// --------------------------------------------------------------------
	localparam [11:0] S_IDLE = 12'h001;
	localparam [11:0] S_ST1 = 12'h002;
	localparam [11:0] S_ST2 = 12'h004;
	localparam [11:0] S_RS1 = 12'h008;
	localparam [11:0] S_RS2 = 12'h010;
	localparam [11:0] S_RS3 = 12'h020;
	localparam [11:0] S_BLO = 12'h040;
	localparam [11:0] S_BHI = 12'h080;
	localparam [11:0] S_SP1 = 12'h100;
	localparam [11:0] S_SP2 = 12'h200;
	localparam [11:0] S_SP3 = 12'h400;

	// --------------------------------------------------------------------
	// Storage
	// --------------------------------------------------------------------
	reg [3:0] port_mode_select;
	reg port_enable_bit;
	reg fw_scl_low;
	reg fw_sda_low;
	reg write_collision_flag;
	reg start_request;
	reg repeat_start_request;
	reg stop_request;
	reg rx_request;
	reg ack_request;
	reg ack_data;
	reg ack_status;
	reg start_seen;
	reg stop_seen;
	reg port_irq_flag;
	reg bus_collision_flag;
	reg buf_full;
	reg tx_go;
	reg [7:0] address_baud_register;
	reg [7:0] shift_buffer;
	reg [8:0] shreg;
	reg [3:0] bits_left;
	reg [7:0] baud_generator;
	reg [11:0] state;
	reg [11:0] next_state;
	reg wait_ok;
	reg coll;
	reg sda_m;
	reg sda_s;
	reg sda_p;
	reg scl_m;
	reg scl_s;
	reg scl_p;

	wire host_on;
	wire fw_on;
	wire tmo;
	wire busy;
	wire gen_req;
	wire det_start;
	wire det_stop;
	wire wr_ctl1;
	wire wr_ctl2;
	wire wr_stat;
	wire wr_baud;
	wire wr_buf;
	wire [8:0] shnext;

	// Host and firmware modes both need the port enabled
	assign host_on = port_enable_bit && (port_mode_select == `IHSR_MODE_HOST);
	assign fw_on = port_enable_bit && (port_mode_select == `IHSR_MODE_FW);
	assign busy = (state != S_IDLE) || start_request || repeat_start_request ||
		stop_request || rx_request || ack_request || tx_go;
	// Detection is blind to our own start/stop generation
	assign gen_req = start_request || stop_request;
	assign det_start = (host_on || fw_on) && !gen_req && scl_p && scl_s && sda_p && !sda_s;
	assign det_stop = (host_on || fw_on) && !gen_req && scl_p && scl_s && !sda_p && sda_s;
	assign tmo = wait_ok && (baud_generator == 8'h00);
	assign wr_ctl1 = WR_I && (ADDR_I == `IHSR_OFF_CTL1);
	assign wr_ctl2 = WR_I && (ADDR_I == `IHSR_OFF_CTL2);
	assign wr_stat = WR_I && (ADDR_I == `IHSR_OFF_STAT);
	assign wr_baud = WR_I && (ADDR_I == `IHSR_OFF_BAUD);
	assign wr_buf = WR_I && (ADDR_I == `IHSR_OFF_BUF);
	// Sampled SDA enters at the bottom, next bit to send leaves at the top
	assign shnext = {shreg[7:0], sda_s};

	// --------------------------------------------------------------------
	// Pin synchronisers
	// --------------------------------------------------------------------
	// Two stages per pin; the third copy only feeds edge detection
	always @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_p <= 1'b1;
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			scl_p <= 1'b1;
		end else begin
			sda_m <= SDA_I;
			sda_s <= sda_m;
			sda_p <= sda_s;
			scl_m <= SCL_I;
			scl_s <= scl_m;
			scl_p <= scl_s;
		end
	end

	// --------------------------------------------------------------------
	// Sequencer next state and counting condition
	// --------------------------------------------------------------------
	// wait_ok low holds the baud generator at its reload value
	always @* begin
		next_state = state;
		wait_ok = 1'b0;
		coll = 1'b0;
		case (state)
			S_IDLE: begin
				if (host_on) begin
					if (start_request)
						next_state = S_ST1;
					else if (repeat_start_request)
						next_state = S_RS1;
					else if (stop_request)
						next_state = S_SP1;
					else if (rx_request || ack_request || tx_go)
						next_state = S_BLO;
				end
			end
			S_ST1: begin
				wait_ok = sda_s && scl_s;
				coll = !(sda_s && scl_s);
				if (tmo)
					next_state = S_ST2;
			end
			S_ST2: begin
				wait_ok = 1'b1;
				if (tmo)
					next_state = S_IDLE;
			end
			S_RS1: begin
				wait_ok = !scl_s;
				coll = tmo && !sda_s;
				if (tmo)
					next_state = S_RS2;
			end
			S_RS2: begin
				wait_ok = scl_s;
				coll = (scl_s && !sda_s) || (scl_p && !scl_s);
				if (tmo)
					next_state = S_RS3;
			end
			S_RS3: begin
				wait_ok = 1'b1;
				if (tmo)
					next_state = S_IDLE;
			end
			S_BLO: begin
				wait_ok = 1'b1;
				if (tmo)
					next_state = S_BHI;
			end
			S_BHI: begin
				wait_ok = scl_s;
				if (tmo && (bits_left == 4'h1))
					next_state = S_IDLE;
				else if (tmo)
					next_state = S_BLO;
			end
			S_SP1: begin
				wait_ok = 1'b1;
				if (tmo)
					next_state = S_SP2;
			end
			S_SP2: begin
				wait_ok = scl_s;
				if (tmo)
					next_state = S_SP3;
			end
			S_SP3: begin
				wait_ok = 1'b1;
				if (tmo)
					next_state = S_IDLE;
			end
			default: begin
				next_state = S_IDLE;
			end
		endcase
		if (coll || !host_on)
			next_state = S_IDLE;
	end

	// --------------------------------------------------------------------
	// Baud generator
	// --------------------------------------------------------------------
	// Reloads on every state change and while stalled, so a stretched SCL
	// still gets a full high period after it is finally seen high
	always @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I)
			baud_generator <= `IHSR_RST_BAUD;
		else if ((next_state != state) || !wait_ok)
			baud_generator <= address_baud_register;
		else if (baud_generator != 8'h00)
			baud_generator <= baud_generator - 8'h01;
	end

	// --------------------------------------------------------------------
	// Registers, flags and pin drive
	// --------------------------------------------------------------------
	// Software effects come first; hardware sets follow so a set wins
	always @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			state <= S_IDLE;
			port_mode_select <= 4'h0;
			port_enable_bit <= 1'b0;
			fw_scl_low <= 1'b0;
			fw_sda_low <= 1'b0;
			write_collision_flag <= 1'b0;
			start_request <= 1'b0;
			repeat_start_request <= 1'b0;
			stop_request <= 1'b0;
			rx_request <= 1'b0;
			ack_request <= 1'b0;
			ack_data <= 1'b0;
			ack_status <= 1'b0;
			start_seen <= 1'b0;
			stop_seen <= 1'b0;
			port_irq_flag <= 1'b0;
			bus_collision_flag <= 1'b0;
			buf_full <= 1'b0;
			tx_go <= 1'b0;
			address_baud_register <= `IHSR_RST_BAUD;
			shift_buffer <= 8'h00;
			shreg <= 9'h1ff;
			bits_left <= 4'h0;
			SDA_O <= 1'b0;
			SCL_O <= 1'b0;
			SDA_OE_O <= 1'b0;
			SCL_OE_O <= 1'b0;
			RDATA_O <= 8'h00;
		end else begin
			state <= next_state;
			SDA_O <= 1'b0;
			SCL_O <= 1'b0;
			// Software writes
			if (wr_ctl1) begin
				port_mode_select <= WDATA_I[`IHSR_C1_MODE_HI:`IHSR_C1_MODE_LO];
				port_enable_bit <= WDATA_I[`IHSR_C1_EN];
				fw_scl_low <= WDATA_I[`IHSR_C1_FW_SCL];
				fw_sda_low <= WDATA_I[`IHSR_C1_FW_SDA];
				// Writing zero clears the collision flag
				if (!WDATA_I[`IHSR_C1_WRITE_COLLISION_FLAG])
					write_collision_flag <= 1'b0;
			end
			// Requests are taken only while nothing runs; one write may set several
			if (wr_ctl2) begin
				ack_data <= WDATA_I[`IHSR_C2_ACKDATA];
				if (host_on && !busy) begin
					start_request <= WDATA_I[`IHSR_C2_START];
					repeat_start_request <= WDATA_I[`IHSR_C2_RSTART];
					stop_request <= WDATA_I[`IHSR_C2_STOP];
					rx_request <= WDATA_I[`IHSR_C2_RX];
					ack_request <= WDATA_I[`IHSR_C2_ACKEN];
				end
			end
			// Interrupt and bus collision flags clear by writing one
			if (wr_stat) begin
				if (WDATA_I[`IHSR_ST_IRQ])
					port_irq_flag <= 1'b0;
				if (WDATA_I[`IHSR_ST_BCOL])
					bus_collision_flag <= 1'b0;
			end
			if (wr_baud)
				address_baud_register <= WDATA_I;
			// Buffer write starts a byte only from idle
			if (wr_buf) begin
				if (busy || !host_on) begin
					write_collision_flag <= 1'b1;
				end else begin
					shift_buffer <= WDATA_I;
					tx_go <= 1'b1;
				end
			end
			// Buffer read frees the buffer
			if (RD_I && (ADDR_I == `IHSR_OFF_BUF))
				buf_full <= 1'b0;
			// Bus start/stop detection, also live during a repeated start
			// A repeated start of our own flags only when its count runs out
			if (det_start) begin
				start_seen <= 1'b1;
				stop_seen <= 1'b0;
				if (!repeat_start_request)
					port_irq_flag <= 1'b1;
			end
			if (det_stop) begin
				stop_seen <= 1'b1;
				start_seen <= 1'b0;
				port_irq_flag <= 1'b1;
			end
			// Sequencer actions
			case (state)
				S_IDLE: begin
					if (next_state == S_BLO) begin
						SCL_OE_O <= 1'b1;
						if (tx_go) begin
							// Buffer byte then ack slot from the receiver
							shreg <= {shift_buffer, 1'b1};
							bits_left <= `IHSR_BITS_TX;
							SDA_OE_O <= !shift_buffer[7];
						end else if (rx_request) begin
							shreg <= 9'h1ff;
							bits_left <= `IHSR_BITS_RX;
							SDA_OE_O <= 1'b0;
						end else begin
							shreg <= {ack_data, 8'hff};
							bits_left <= `IHSR_BITS_ACK;
							SDA_OE_O <= !ack_data;
						end
					end else if (next_state == S_RS1) begin
						SCL_OE_O <= 1'b1;
						SDA_OE_O <= 1'b0;
					end else if (next_state == S_SP1) begin
						SCL_OE_O <= 1'b1;
						SDA_OE_O <= 1'b1;
					end
				end
				S_ST1: begin
					if (tmo) begin
						SDA_OE_O <= 1'b1;
						start_seen <= 1'b1;
						stop_seen <= 1'b0;
					end
				end
				S_ST2: begin
					if (tmo) begin
						start_request <= 1'b0;
						port_irq_flag <= 1'b1;
					end
				end
				S_RS1: begin
					if (tmo && sda_s)
						SCL_OE_O <= 1'b0;
				end
				S_RS2: begin
					if (tmo && !coll)
						SDA_OE_O <= 1'b1;
				end
				S_RS3: begin
					if (tmo) begin
						// Bus stays owned: SCL held low, SDA low
						SCL_OE_O <= 1'b1;
						repeat_start_request <= 1'b0;
						port_irq_flag <= 1'b1;
					end
				end
				S_BLO: begin
					if (tmo)
						SCL_OE_O <= 1'b0;
				end
				S_BHI: begin
					if (tmo) begin
						SCL_OE_O <= 1'b1;
						shreg <= shnext;
						bits_left <= bits_left - 4'h1;
						if (bits_left == 4'h1) begin
							port_irq_flag <= 1'b1;
							if (tx_go) begin
								tx_go <= 1'b0;
								ack_status <= sda_s;
								SDA_OE_O <= 1'b0;
							end else if (rx_request) begin
								rx_request <= 1'b0;
								shift_buffer <= shnext[7:0];
								buf_full <= 1'b1;
							end else begin
								ack_request <= 1'b0;
								SDA_OE_O <= 1'b0;
							end
						end else begin
							SDA_OE_O <= !shreg[7];
						end
					end
				end
				S_SP1: begin
					if (tmo)
						SCL_OE_O <= 1'b0;
				end
				S_SP2: begin
					if (tmo)
						SDA_OE_O <= 1'b0;
				end
				S_SP3: begin
					if (tmo) begin
						stop_request <= 1'b0;
						stop_seen <= 1'b1;
						start_seen <= 1'b0;
						port_irq_flag <= 1'b1;
					end
				end
				default: begin
					SDA_OE_O <= 1'b0;
				end
			endcase
			// Collision: flag it, drop the sequence, let go of both lines
			if (coll) begin
				bus_collision_flag <= 1'b1;
				start_request <= 1'b0;
				repeat_start_request <= 1'b0;
				SDA_OE_O <= 1'b0;
				SCL_OE_O <= 1'b0;
			end
			// Firmware mode hands the lines straight to software
			if (fw_on) begin
				SDA_OE_O <= fw_sda_low;
				SCL_OE_O <= fw_scl_low;
			end else if (!host_on) begin
				SDA_OE_O <= 1'b0;
				SCL_OE_O <= 1'b0;
				start_request <= 1'b0;
				repeat_start_request <= 1'b0;
				stop_request <= 1'b0;
				rx_request <= 1'b0;
				ack_request <= 1'b0;
				tx_go <= 1'b0;
			end
			// A disabled port forgets what it saw on the bus
			if (!port_enable_bit) begin
				start_seen <= 1'b0;
				stop_seen <= 1'b0;
			end
			// Read data, valid in the cycle after the strobe
			if (RD_I) begin
				case (ADDR_I)
					`IHSR_OFF_CTL1:
						RDATA_O <= {write_collision_flag, fw_sda_low, port_enable_bit,
							fw_scl_low, port_mode_select};
					`IHSR_OFF_CTL2:
						RDATA_O <= {1'b0, ack_status, ack_data, ack_request, rx_request,
							stop_request, repeat_start_request, start_request};
					`IHSR_OFF_STAT:
						RDATA_O <= {2'b00, busy, buf_full, bus_collision_flag,
							port_irq_flag, stop_seen, start_seen};
					`IHSR_OFF_BAUD:
						RDATA_O <= address_baud_register;
					`IHSR_OFF_BUF:
						RDATA_O <= shift_buffer;
					default:
						RDATA_O <= 8'h00;
				endcase
			end else begin
				RDATA_O <= 8'h00;
			end
		end
	end

endmodule

// File: test/ihsr_core_assertions.sv
// Port checker for the I2C host start/restart controller.
// Bound to ihsr_core; mirrors control and baud writes on its own.
`timescale 1ns/1ns
`include "ihsr_map.vh"
module ihsr_core_assertions (
	input wire MCLK_I,
	input wire RST_I,
	input wire [7:0] ADDR_I,
	input wire [7:0] WDATA_I,
	input wire WR_I,
	input wire RD_I,
	input wire [7:0] RDATA_O,
	input wire SDA_I,
	input wire SCL_I,
	input wire SDA_O,
	input wire SDA_OE_O,
	input wire SCL_O,
	input wire SCL_OE_O
);
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (RST_I);
	// --------
	// Shadow state
	// --------
	reg [7:0] c1;
	reg [7:0] baud;
	reg [15:0] hi_cnt;
	reg [15:0] lo_cnt;
	wire host = c1[3:0] == `IHSR_MODE_HOST && c1[5];
	wire fw = c1[3:0] == `IHSR_MODE_FW && c1[5];
	wire [15:0] per = {8'h00, baud} + 16'd1;
	// Mirror writes; count free SCL high time and SDA held low under it
	always @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			c1 <= 8'h00;
			baud <= `IHSR_RST_BAUD;
			hi_cnt <= 16'h0000;
			lo_cnt <= 16'h0000;
		end else begin
			if (WR_I && ADDR_I == `IHSR_OFF_CTL1)
				c1 <= WDATA_I;
			if (WR_I && ADDR_I == `IHSR_OFF_BAUD)
				baud <= WDATA_I;
			hi_cnt <= (SCL_I && !SCL_OE_O) ? hi_cnt + 16'd1 : 16'h0000;
			lo_cnt <= (SCL_I && !SCL_OE_O && SDA_OE_O) ? lo_cnt + 16'd1 : 16'h0000;
		end
	end
	// Port disabled for two samples; one cycle covers the clearing edge
	sequence off_two;
		!c1[5] ##1 !c1[5];
	endsequence
	drain_zero_a: assert property (SDA_O == 1'b0 && SCL_O == 1'b0)
		else $error("pin value not zero");
	rd_idle_a: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
		else $error("read data outside its slot");
	rd_unmapped_a: assert property ($past(RD_I) && $past(ADDR_I) > `IHSR_OFF_BUF
		|-> RDATA_O == 8'h00) else $error("unmapped read not zero");
	off_quiet_a: assert property (off_two |-> !SDA_OE_O && !SCL_OE_O)
		else $error("pin pulled while disabled");
	seen_clear_a: assert property (off_two ##0 (RD_I && ADDR_I == `IHSR_OFF_STAT)
		|=> RDATA_O[1:0] == 2'b00) else $error("seen bits set while disabled");
	fw_follow_a: assert property (fw && $past(fw) |-> SCL_OE_O == $past(c1[4])
		&& SDA_OE_O == $past(c1[6])) else $error("firmware pins not followed");
	scl_high_a: assert property ($rose(SCL_OE_O) && host |-> hi_cnt >= per)
		else $error("SCL high time short");
	sda_hold_a: assert property ($rose(SCL_OE_O) && $past(SDA_OE_O) && host
		|-> lo_cnt >= per) else $error("SDA low under SCL high too short");
	sda_edge_a: assert property ($rose(SDA_OE_O) && host |-> SCL_OE_O || SCL_I)
		else $error("SDA pulled while SCL held by another");
endmodule

bind ihsr_core ihsr_core_assertions ihsr_core_assertions_inst (
	.MCLK_I(MCLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
	.WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .SDA_I(SDA_I), .SCL_I(SCL_I),
	.SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .SCL_O(SCL_O), .SCL_OE_O(SCL_OE_O)
);

// File: test/ihsr_bus_model.sv
// Bus partner: pull-ups and a client that shifts in bytes and acks each.
// The bench may stretch SCL or pull SDA as a rival host through the hooks.
`timescale 1ns/1ns
module ihsr_bus_model (
	input wire dev_sda_oe_i,
	input wire dev_scl_oe_i,
	input wire hold_scl_i,
	input wire hold_sda_i,
	output wire sda_o,
	output wire scl_o,
	output reg [7:0] rx_byte_o
);
	reg [3:0] bit_cnt = 4'h0;
	reg [3:0] n;
	reg [7:0] starts = 8'h00;
	reg [7:0] mark = 8'h00;
	reg ack_pull = 1'b0;
	initial rx_byte_o = 8'h00;
	// Wired-AND with pull-ups: a released line reads high, never stale
	assign sda_o = !(dev_sda_oe_i || hold_sda_i || ack_pull);
	assign scl_o = !(dev_scl_oe_i || hold_scl_i);
	// Start on the lines; counted so the shifter can realign
	always @(negedge sda_o) begin
		if (scl_o)
			starts <= starts + 8'h01;
	end
	// Eight data bits MSB first after a start, then the ack slot
	always @(posedge scl_o) begin
		n = (mark != starts) ? 4'h0 : bit_cnt;
		mark <= starts;
		if (n < 4'h8)
			rx_byte_o <= {rx_byte_o[6:0], sda_o};
		bit_cnt <= (n == 4'h8) ? 4'h0 : n + 4'h1;
	end
	// Receiver pulls SDA through the ninth clock of every byte
	always @(negedge scl_o) begin
		ack_pull <= (bit_cnt == 4'h8);
	end
endmodule

// File: test/ihsr_core_tb_top.sv
// Self-checking bench for ihsr_core over its register port.
// Far side is ihsr_bus_model; MCLK_I runs at 100 MHz.
`timescale 1ns/1ns
`include "ihsr_map.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module ihsr_core_tb_top;
	reg mclk = 1'b0;
	reg rst = 1'b1;
	reg [7:0] addr = 8'h00;
	reg [7:0] wdata = 8'h00;
	reg wr_s = 1'b0;
	reg rd_s = 1'b0;
	reg hold_scl = 1'b0;
	reg hold_sda = 1'b0;
	reg [7:0] d = 8'h00;
	wire [7:0] rdata;
	wire [7:0] rx_byte;
	wire sda;
	wire scl;
	wire sda_oe;
	wire scl_oe;
	integer mismatches = 0;
	integer cmp_count = 0;
	// --------
	// Design, partner, clock
	// --------
	ihsr_core ihsr_core_inst (
		.MCLK_I(mclk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s),
		.RD_I(rd_s), .RDATA_O(rdata), .SDA_I(sda), .SCL_I(scl), .SDA_O(),
		.SDA_OE_O(sda_oe), .SCL_O(), .SCL_OE_O(scl_oe)
	);
	ihsr_bus_model ihsr_bus_model_inst (
		.dev_sda_oe_i(sda_oe), .dev_scl_oe_i(scl_oe), .hold_scl_i(hold_scl),
		.hold_sda_i(hold_sda), .sda_o(sda), .scl_o(scl), .rx_byte_o(rx_byte)
	);
	always #5 mclk = ~mclk;
	// One-cycle strobes launched just after an edge
	task wr(input [7:0] a, input [7:0] v);
		begin
			@(posedge mclk);
			addr <= a;
			wdata <= v;
			wr_s <= 1'b1;
			@(posedge mclk);
			wr_s <= 1'b0;
		end
	endtask
	// Data stand only in the cycle after the strobe
	task rd(input [7:0] a, output [7:0] v);
		begin
			@(posedge mclk);
			addr <= a;
			rd_s <= 1'b1;
			@(posedge mclk);
			rd_s <= 1'b0;
			#1 v = rdata;
		end
	endtask
	// Poll a status bit with a bound, then clear the interrupt and bus collision flags
	task wait_stat(input integer b);
		integer k;
		begin
			k = 0;
			d = 8'h00;
			while (d[b] !== 1'b1 && k < 300) begin
				rd(`IHSR_OFF_STAT, d);
				k = k + 1;
			end
			`CHK(d[b], 1'b1)
			wr(`IHSR_OFF_STAT, 8'h0c);
		end
	endtask
	task fin(input string s);
		$display("test %s done", s);
	endtask
	task test_done;
		begin
			$display("compares %0d mismatches %0d", cmp_count, mismatches);
			if (mismatches == 0 && cmp_count > 0) begin
				$display("DONE - PASS");
			end else begin
				$display("DONE - FAIL");
			end
			$finish;
		end
	endtask
	// Hang guard well beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge mclk);
		mismatches++;
		test_done;
	end
	// --------
	// Tests
	// --------
	initial begin
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		rd(`IHSR_OFF_BAUD, d);
		`CHK(d, `IHSR_RST_BAUD)
		rd(`IHSR_OFF_STAT, d);
		`CHK(d, 8'h00)
		wr(8'h14, 8'hff);
		rd(8'h14, d);
		`CHK(d, 8'h00)
		wr(`IHSR_OFF_CTL1, 8'h20);
		wr(`IHSR_OFF_CTL2, 8'h01);
		rd(`IHSR_OFF_CTL2, d);
		`CHK(d, 8'h00)
		`CHK(sda_oe, 1'b0)
		fin("reset");
		// Software makes a start and a stop by hand
		wr(`IHSR_OFF_CTL1, 8'h6b);
		wait_stat(2);
		rd(`IHSR_OFF_STAT, d);
		`CHK(d[0], 1'b1)
		wr(`IHSR_OFF_CTL1, 8'h2b);
		wait_stat(2);
		rd(`IHSR_OFF_STAT, d);
		`CHK(d[1], 1'b1)
		wr(`IHSR_OFF_CTL1, 8'h0b);
		rd(`IHSR_OFF_STAT, d);
		`CHK(d[1:0], 2'b00)
		fin("firmware");
		// Start with writes thrown at it; slow baud leaves room for them
		wr(`IHSR_OFF_BAUD, 8'h10);
		wr(`IHSR_OFF_CTL1, 8'h28);
		wr(`IHSR_OFF_CTL2, 8'h01);
		wr(`IHSR_OFF_BUF, 8'h5a);
		wr(`IHSR_OFF_CTL2, 8'h04);
		rd(`IHSR_OFF_CTL2, d);
		`CHK(d[2:0], 3'b001)
		rd(`IHSR_OFF_CTL1, d);
		`CHK(d[7], 1'b1)
		wait_stat(2);
		rd(`IHSR_OFF_CTL2, d);
		`CHK(d[0], 1'b0)
		rd(`IHSR_OFF_STAT, d);
		`CHK(d[0], 1'b1)
		`CHK({sda_oe, scl_oe}, 2'b10)
		fin("start");
		// Address byte at a 100 ns SCL, stretched by the client
		wr(`IHSR_OFF_CTL1, 8'h28);
		wr(`IHSR_OFF_BAUD, 8'h03);
		wr(`IHSR_OFF_BUF, 8'ha4);
		wr(`IHSR_OFF_BUF, 8'h33);
		wr(`IHSR_OFF_CTL2, 8'h02);
		rd(`IHSR_OFF_CTL2, d);
		`CHK(d[1], 1'b0)
		rd(`IHSR_OFF_CTL1, d);
		`CHK(d[7], 1'b1)
		// Client stretches only a low phase the host began, never a high one
		while (scl_oe !== 1'b0)
			@(negedge mclk);
		while (scl_oe !== 1'b1)
			@(negedge mclk);
		@(posedge mclk);
		hold_scl <= 1'b1;
		repeat (30) @(posedge mclk);
		hold_scl <= 1'b0;
		wait_stat(2);
		`CHK(rx_byte, 8'ha4)
		rd(`IHSR_OFF_CTL2, d);
		`CHK(d[6], 1'b0)
		fin("byte");
		// Repeated start keeps the bus
		wr(`IHSR_OFF_CTL1, 8'h28);
		wr(`IHSR_OFF_CTL2, 8'h02);
		wait_stat(2);
		rd(`IHSR_OFF_CTL2, d);
		`CHK(d[1], 1'b0)
		rd(`IHSR_OFF_STAT, d);
		`CHK(d[0], 1'b1)
		`CHK({sda_oe, scl_oe}, 2'b11)
		fin("restart");
		// Stop from the owned bus; own detection stays blind to it
		wr(`IHSR_OFF_CTL2, 8'h04);
		wait_stat(2);
		rd(`IHSR_OFF_CTL2, d);
		`CHK(d[2], 1'b0)
		rd(`IHSR_OFF_STAT, d);
		`CHK(d[1:0], 2'b10)
		`CHK({sda_oe, scl_oe}, 2'b00)
		fin("stop");
		// A rival keeps SDA low through a repeated start
		@(posedge mclk);
		hold_sda <= 1'b1;
		wr(`IHSR_OFF_CTL2, 8'h02);
		wait_stat(3);
		rd(`IHSR_OFF_CTL2, d);
		`CHK(d[1], 1'b0)
		`CHK({sda_oe, scl_oe}, 2'b00)
		fin("restart collision");
		// Both lines already low when a start is asked for
		@(posedge mclk);
		hold_scl <= 1'b1;
		wr(`IHSR_OFF_CTL2, 8'h01);
		wait_stat(3);
		rd(`IHSR_OFF_CTL2, d);
		`CHK(d[0], 1'b0)
		`CHK({sda_oe, scl_oe}, 2'b00)
		@(posedge mclk);
		hold_sda <= 1'b0;
		hold_scl <= 1'b0;
		fin("start collision");
		// Reset in mid-run clears seen bits and the mode
		@(posedge mclk);
		rst <= 1'b1;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		rd(`IHSR_OFF_STAT, d);
		`CHK(d, 8'h00)
		rd(`IHSR_OFF_CTL1, d);
		`CHK(d, 8'h00)
		fin("second reset");
		test_done;
	end
endmodule
